/* File: hw/ccrp_params.svh */
// Register indices, field positions and reset values of the codec control block
`ifndef CCRP_PARAMS_SVH
`define CCRP_PARAMS_SVH
// Register indices; byte address on the bus is four times the index
`define CCRP_IDX_PAGE   8'h00
`define CCRP_IDX_SRST   8'h01
`define CCRP_IDX_RATE   8'h02
`define CCRP_IDX_PLL    8'h04
`define CCRP_IDX_DPATH  8'h07
`define CCRP_IDX_JTYPE  8'h0D
`define CCRP_IDX_JCFG   8'h0E
`define CCRP_IDX_HPPWR  8'h25
`define CCRP_IDX_SCCTL  8'h26
`define CCRP_IDX_SCSTAT 8'h5F
`define CCRP_IDX_JACKA  8'h60
`define CCRP_IDX_JACKB  8'h61
`define CCRP_IDX_ISTAT  8'h78
`define CCRP_IDX_IMASK  8'h79
// Reset values
`define CCRP_RST_ZERO   8'h00
`define CCRP_RST_PLL    8'h10
`define CCRP_RST_SCCTL  8'h04
// Field positions
`define CCRP_BIT_SRST   7
`define CCRP_BIT_PLLEN  7
`define CCRP_BIT_FSREF  7
`define CCRP_BIT_ACCPL  7
`define CCRP_BIT_HPLPWR 7
`define CCRP_BIT_HPRPWR 6
`define CCRP_BIT_SCEN   2
`define CCRP_BIT_SCAUTO 1
`define CCRP_IRQ_HPL    0
`define CCRP_IRQ_HPR    1
`define CCRP_IRQ_JACK   2
// Highest legal rate selector code
`define CCRP_RATE_MAX   4'hA
`endif

/* File: hw/ccrp_pkg.sv */
// Types shared by the codec control block
package ccrp_pkg;
  typedef logic [7:0] ccrp_byte_t;
  typedef enum logic [1:0] {
    CCRP_OKAY   = 2'h0,
    CCRP_SLVERR = 2'h2
  } ccrp_resp_e;
  typedef enum logic [1:0] {
    CCRP_JT_NONE = 2'h0,
    CCRP_JT_HP   = 2'h1,
    CCRP_JT_MONO = 2'h2,
    CCRP_JT_HSET = 2'h3
  } ccrp_jack_e;
endpackage : ccrp_pkg

/* File: hw/ccrp_prot_if.sv */
// Control and status link between register bank and one driver protector
interface ccrp_prot_if;
  logic pwr_cmd;
  logic prot_en;
  logic auto_pd;
  logic shorted;
  logic in_prot;
  logic tripped;
  logic drv_on;
  modport ctl (output pwr_cmd, prot_en, auto_pd, shorted, input in_prot, tripped, drv_on);
  modport drv (input pwr_cmd, prot_en, auto_pd, shorted, output in_prot, tripped, drv_on);
endinterface : ccrp_prot_if

/* File: hw/ccrp_hp_prot.sv */
// Short-circuit protection state of one high-power headphone driver
module ccrp_hp_prot (
  // Clock, reset, enable
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic srst_i,
  // Register bank side
  ccrp_prot_if.drv  p
);
  logic in_prot_reg;
  logic tripped_reg;
  logic drv_on_reg;
  logic trip_now;

  // Trip only while powered, auto power-down selected and limit engaged
  assign trip_now = p.auto_pd & p.prot_en & p.shorted & p.pwr_cmd;

  // Limit flag follows the short while protection is enabled
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_prot_reg <= 1'b0;
    end else if (ce_i) begin
      in_prot_reg <= !srst_i && p.prot_en && p.shorted;
    end
  end

  // Latched trip; a new trip wins over the clear from a power-off command
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tripped_reg <= 1'b0;
    end else if (ce_i) begin
      if (srst_i) begin
        tripped_reg <= 1'b0;
      end else if (trip_now) begin
        tripped_reg <= 1'b1;
      end else if (!p.pwr_cmd) begin
        tripped_reg <= 1'b0;
      end
    end
  end

  // Driver stays down after a trip until commanded off and on again
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_on_reg <= 1'b0;
    end else if (ce_i) begin
      drv_on_reg <= !srst_i && p.pwr_cmd && !tripped_reg && !trip_now;
    end
  end

  assign p.in_prot = in_prot_reg;
  assign p.tripped = tripped_reg;
  assign p.drv_on  = drv_on_reg;

  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence trip_s;
    ce_i && !srst_i && trip_now;
  endsequence
  sequence stay_s;
    ce_i && !srst_i && tripped_reg && p.pwr_cmd;
  endsequence

  auto_trip_a: assert property (trip_s |=> tripped_reg && !drv_on_reg)
    else $error("driver not powered down on short");
  trip_hold_a: assert property (stay_s |=> tripped_reg && !drv_on_reg)
    else $error("tripped driver came back without off command");
  trip_clr_a: assert property (ce_i && tripped_reg && !p.pwr_cmd && !srst_i |=> !tripped_reg)
    else $error("off command did not clear trip flag");
endmodule : ccrp_hp_prot

/* File: hw/ccrp_ctrl_regs.sv */
// Codec control register bank with AXI4-Lite access and driver protection
//
// The implementer's own choice: the AXI4-Lite register port.
`include "ccrp_params.svh"
module ccrp_ctrl_regs (
  // Clock, reset, enable
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  // AXI4-Lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog status
  input  wire logic        hpl_short_i,
  input  wire logic        hpr_short_i,
  input  wire logic [1:0]  jack_type_i,
  // Analog and clock controls
  output logic             left_headphone_out_on_o,
  output logic             right_headphone_out_on_o,
  output logic             sc_limit_en_o,
  output logic             soft_rst_o,
  output logic [3:0]       adc_div_x2_o,
  output logic [3:0]       dac_div_x2_o,
  output logic             fs_ref_441_o,
  output logic             pll_en_o,
  output logic [4:0]       pll_q_o,
  output logic [3:0]       pll_p_o,
  output logic [23:0]      jack_cfg_o,
  // Interrupt
  output logic             irq_o
);
  ccrp_prot_if hpl_if ();
  ccrp_prot_if hpr_if ();

  logic                page_reg;
  logic                srst_reg;
  ccrp_pkg::ccrp_byte_t rate_reg, pll_reg, dpath_reg, jctl_reg, jcfg_reg;
  ccrp_pkg::ccrp_byte_t pwr_reg, scctl_reg, jacka_reg, jackb_reg;
  logic [1:0]          jt_reg, jt_next;
  logic [2:0]          istat_reg, imask_reg, istat_next, ev;
  logic [1:0]          flag_prev_reg;
  logic [9:0]          aw_addr_reg;
  logic [7:0]          wd_reg;
  logic                aw_held_reg, w_held_reg, wstrb0_reg;
  logic                awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0]          bresp_reg, rresp_reg;
  logic [31:0]         rdata_reg;
  logic [7:0]          aw_idx, ar_idx;
  logic                wr_go, wr_fire, wr_p0, ar_hit, aw_hit;
  ccrp_pkg::ccrp_byte_t rd_byte;

  // Route every index but the page bit to the active page; page 1 is empty
  function automatic logic idx_hit(input logic [7:0] idx, input logic pg);
    logic h;
    h = 1'b0;
    if (idx == `CCRP_IDX_PAGE) begin
      h = 1'b1;
    end else if (!pg) begin
      case (idx)
        `CCRP_IDX_SRST, `CCRP_IDX_RATE, `CCRP_IDX_PLL, `CCRP_IDX_DPATH,
        `CCRP_IDX_JTYPE, `CCRP_IDX_JCFG, `CCRP_IDX_HPPWR, `CCRP_IDX_SCCTL,
        `CCRP_IDX_SCSTAT, `CCRP_IDX_JACKA, `CCRP_IDX_JACKB,
        `CCRP_IDX_ISTAT, `CCRP_IDX_IMASK: h = 1'b1;
        default: h = 1'b0;
      endcase
    end
    return h;
  endfunction : idx_hit

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign aw_idx  = aw_addr_reg[9:2];
  assign ar_idx  = s_axi_araddr[9:2];
  assign aw_hit  = idx_hit(aw_idx, page_reg);
  assign ar_hit  = idx_hit(ar_idx, page_reg);
  assign wr_go   = ce_i && aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_fire = wr_go && wstrb0_reg;
  assign wr_p0   = wr_fire && !page_reg;

  // Read mux; only the low byte lane carries data
  always_comb begin
    rd_byte = 8'h00;
    if (ar_idx == `CCRP_IDX_PAGE) begin
      rd_byte = {7'h00, page_reg};
    end else if (!page_reg) begin
      case (ar_idx)
        `CCRP_IDX_RATE:   rd_byte = rate_reg;
        `CCRP_IDX_PLL:    rd_byte = pll_reg;
        `CCRP_IDX_DPATH:  rd_byte = dpath_reg;
        `CCRP_IDX_JTYPE:  rd_byte = {jctl_reg[7], jt_reg, jctl_reg[4:0]};
        `CCRP_IDX_JCFG:   rd_byte = jcfg_reg;
        `CCRP_IDX_HPPWR:  rd_byte = pwr_reg;
        `CCRP_IDX_SCCTL:  rd_byte = scctl_reg;
        `CCRP_IDX_SCSTAT: rd_byte = {hpl_if.in_prot | hpl_if.tripped,
                                     hpr_if.in_prot | hpr_if.tripped, 6'h00};
        `CCRP_IDX_JACKA:  rd_byte = jacka_reg;
        `CCRP_IDX_JACKB:  rd_byte = jackb_reg;
        `CCRP_IDX_ISTAT:  rd_byte = {5'h00, istat_reg};
        `CCRP_IDX_IMASK:  rd_byte = {5'h00, imask_reg};
        default:          rd_byte = 8'h00; // Write-only reset register reads zero
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order, one at a time
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= ccrp_pkg::CCRP_OKAY;
      aw_addr_reg <= 10'h000;
      wd_reg      <= 8'h00;
      wstrb0_reg  <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_awvalid && awready_reg) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wd_reg      <= s_axi_wdata[7:0];
        wstrb0_reg  <= s_axi_wstrb[0];
        w_held_reg  <= 1'b1;
        wready_reg  <= 1'b0;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= aw_hit ? ccrp_pkg::CCRP_OKAY : ccrp_pkg::CCRP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= ccrp_pkg::CCRP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= {24'h00_0000, rd_byte};
        rresp_reg   <= ar_hit ? ccrp_pkg::CCRP_OKAY : ccrp_pkg::CCRP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-clearing soft reset: one pulse, then every control register returns to reset
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      srst_reg <= 1'b0;
    end else if (ce_i) begin
      srst_reg <= wr_p0 && aw_idx == `CCRP_IDX_SRST && wd_reg[`CCRP_BIT_SRST];
    end
  end

  // Control registers; the reset register itself stores nothing
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      page_reg  <= 1'b0;
      rate_reg  <= `CCRP_RST_ZERO;
      pll_reg   <= `CCRP_RST_PLL;
      dpath_reg <= `CCRP_RST_ZERO;
      jctl_reg  <= `CCRP_RST_ZERO;
      jcfg_reg  <= `CCRP_RST_ZERO;
      pwr_reg   <= `CCRP_RST_ZERO;
      scctl_reg <= `CCRP_RST_SCCTL;
      jacka_reg <= `CCRP_RST_ZERO;
      jackb_reg <= `CCRP_RST_ZERO;
      imask_reg <= 3'h0;
    end else if (ce_i) begin
      if (srst_reg) begin
        page_reg  <= 1'b0;
        rate_reg  <= `CCRP_RST_ZERO;
        pll_reg   <= `CCRP_RST_PLL;
        dpath_reg <= `CCRP_RST_ZERO;
        jctl_reg  <= `CCRP_RST_ZERO;
        jcfg_reg  <= `CCRP_RST_ZERO;
        pwr_reg   <= `CCRP_RST_ZERO;
        scctl_reg <= `CCRP_RST_SCCTL;
        jacka_reg <= `CCRP_RST_ZERO;
        jackb_reg <= `CCRP_RST_ZERO;
        imask_reg <= 3'h0;
      end else if (wr_fire && aw_idx == `CCRP_IDX_PAGE) begin
        page_reg <= wd_reg[0];
      end else if (wr_p0) begin
        case (aw_idx)
          `CCRP_IDX_RATE: begin
            // Reserved codes would give no valid rate, so they are dropped
            if (wd_reg[7:4] <= `CCRP_RATE_MAX) rate_reg[7:4] <= wd_reg[7:4];
            if (wd_reg[3:0] <= `CCRP_RATE_MAX) rate_reg[3:0] <= wd_reg[3:0];
          end
          `CCRP_IDX_PLL:   pll_reg   <= wd_reg;
          `CCRP_IDX_DPATH: dpath_reg <= wd_reg;
          `CCRP_IDX_JTYPE: jctl_reg  <= {wd_reg[7], 2'h0, wd_reg[4:0]};
          `CCRP_IDX_JCFG:  jcfg_reg  <= wd_reg;
          `CCRP_IDX_HPPWR: pwr_reg   <= wd_reg;
          `CCRP_IDX_SCCTL: scctl_reg <= wd_reg;
          `CCRP_IDX_JACKA: jacka_reg <= wd_reg;
          `CCRP_IDX_JACKB: jackb_reg <= wd_reg;
          `CCRP_IDX_IMASK: imask_reg <= wd_reg[2:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Jack type; AC-coupled outputs cannot tell mono, so mono reads as plain
  always_comb begin
    jt_next = jack_type_i;
    if (jcfg_reg[`CCRP_BIT_ACCPL] && jack_type_i == ccrp_pkg::CCRP_JT_MONO) begin
      jt_next = ccrp_pkg::CCRP_JT_HP;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      jt_reg <= ccrp_pkg::CCRP_JT_NONE;
    end else if (ce_i) begin
      jt_reg <= jt_next;
    end
  end

  // Events: protection entered on either driver, jack type changed
  assign ev = {jt_reg != jt_next,
               (hpr_if.in_prot | hpr_if.tripped) & !flag_prev_reg[1],
               (hpl_if.in_prot | hpl_if.tripped) & !flag_prev_reg[0]};
  // Set wins over a write-one clear in the same cycle
  assign istat_next = (istat_reg & ~((wr_p0 && aw_idx == `CCRP_IDX_ISTAT) ?
                      wd_reg[2:0] : 3'h0)) | ev;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      istat_reg     <= 3'h0;
      flag_prev_reg <= 2'h0;
      irq_o         <= 1'b0;
    end else if (ce_i) begin
      flag_prev_reg <= {hpr_if.in_prot | hpr_if.tripped, hpl_if.in_prot | hpl_if.tripped};
      istat_reg     <= srst_reg ? 3'h0 : istat_next;
      irq_o         <= !srst_reg && |(istat_next & imask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver protection, one instance per high-power driver
  assign hpl_if.pwr_cmd = pwr_reg[`CCRP_BIT_HPLPWR];
  assign hpr_if.pwr_cmd = pwr_reg[`CCRP_BIT_HPRPWR];
  assign hpl_if.prot_en = scctl_reg[`CCRP_BIT_SCEN];
  assign hpr_if.prot_en = scctl_reg[`CCRP_BIT_SCEN];
  assign hpl_if.auto_pd = scctl_reg[`CCRP_BIT_SCAUTO];
  assign hpr_if.auto_pd = scctl_reg[`CCRP_BIT_SCAUTO];
  assign hpl_if.shorted = hpl_short_i;
  assign hpr_if.shorted = hpr_short_i;

  ccrp_hp_prot u_hpl (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .srst_i     (srst_reg),
    .p          (hpl_if)
  );
  ccrp_hp_prot u_hpr (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .ce_i       (ce_i),
    .srst_i     (srst_reg),
    .p          (hpr_if)
  );

  // Decoded controls, registered so every output comes from a flop
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      adc_div_x2_o  <= 4'h2;
      dac_div_x2_o  <= 4'h2;
      fs_ref_441_o  <= 1'b0;
      pll_en_o      <= 1'b0;
      pll_q_o       <= 5'h02;
      pll_p_o       <= 4'h8;
      sc_limit_en_o <= 1'b1;
      jack_cfg_o    <= 24'h00_0000;
    end else if (ce_i) begin
      adc_div_x2_o  <= rate_reg[7:4] + 4'h2;
      dac_div_x2_o  <= rate_reg[3:0] + 4'h2;
      fs_ref_441_o  <= dpath_reg[`CCRP_BIT_FSREF];
      pll_en_o      <= pll_reg[`CCRP_BIT_PLLEN];
      pll_q_o       <= (pll_reg[6:4] == 3'h0 && !pll_reg[3]) ? 5'h10 :
                       (pll_reg[6:4] == 3'h0) ? 5'h11 : {1'b0, pll_reg[6:3]};
      pll_p_o       <= (pll_reg[2:0] == 3'h0) ? 4'h8 : {1'b0, pll_reg[2:0]};
      sc_limit_en_o <= scctl_reg[`CCRP_BIT_SCEN];
      jack_cfg_o    <= {jcfg_reg, jacka_reg, jackb_reg};
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign soft_rst_o    = srst_reg;
  assign left_headphone_out_on_o  = hpl_if.drv_on;
  assign right_headphone_out_on_o = hpr_if.drv_on;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  logic ar_take;
  assign ar_take = ce_i && s_axi_arvalid && arready_reg;

  reg_width_a: assert property (rvalid_reg |-> rdata_reg[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  page_read_a: assert property (ar_take && ar_idx == `CCRP_IDX_PAGE
    |=> rdata_reg == {31'h0000_0000, $past(page_reg)})
    else $error("page register read wrong");
  srst_pulse_a: assert property (wr_p0 && aw_idx == `CCRP_IDX_SRST && wd_reg[7] && !srst_reg
    |=> srst_reg ##1 !srst_reg && rate_reg == 8'h00 && pll_reg == 8'h10)
    else $error("soft reset did not pulse and clear");
  rate_rsv_a: assert property (wr_p0 && !srst_reg && aw_idx == `CCRP_IDX_RATE
    && wd_reg[7:4] > 4'hA |=> rate_reg[7:4] == $past(rate_reg[7:4]))
    else $error("reserved rate code stored");
  page_route_a: assert property (wr_fire && page_reg && aw_idx != `CCRP_IDX_PAGE
    && !srst_reg |=> $stable(rate_reg) && $stable(pll_reg) && $stable(scctl_reg))
    else $error("page 1 write reached page 0");
  pll_en_a: assert property (ce_i |=> pll_en_o == $past(pll_reg[7]))
    else $error("PLL enable does not follow control bit");
  pll_q_a: assert property (ce_i |=> pll_q_o == ($past(pll_reg[6:3]) < 4'h2 ?
    5'h10 + {4'h0, $past(pll_reg[3])} : {1'b0, $past(pll_reg[6:3])}))
    else $error("Q divider decode wrong");
  pll_p_a: assert property (ce_i |=> pll_p_o == ($past(pll_reg[2:0]) == 3'h0 ?
    4'h8 : {1'b0, $past(pll_reg[2:0])}))
    else $error("P predivider decode wrong");
  fs_ref_a: assert property (ce_i |=> fs_ref_441_o == $past(dpath_reg[7]))
    else $error("reference rate select lost");
  jack_read_a: assert property (ar_take && !page_reg && ar_idx == `CCRP_IDX_JTYPE
    |=> rdata_reg[6:5] == $past(jt_reg))
    else $error("jack type read wrong");
  ac_mono_a: assert property (ce_i && jcfg_reg[7] && jack_type_i == 2'h2
    |=> jt_reg == 2'h1)
    else $error("mono reported in ac-coupled mode");
  sc_stat_a: assert property (ar_take && !page_reg && ar_idx == `CCRP_IDX_SCSTAT
    |=> rdata_reg[7] == $past(hpl_if.in_prot | hpl_if.tripped))
    else $error("protection status read wrong");
endmodule : ccrp_ctrl_regs

/* File: sim/ccrp_ctrl_regs_tb.sv */
// Self-checking testbench of the codec control register bank over AXI4-Lite
`include "ccrp_params.svh"
module ccrp_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  logic        core_clk_i, nrst_i, ce_i;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, pll_p_o, adc_div_x2_o, dac_div_x2_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp, jack_type_i;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, hpl_short_i, hpr_short_i;
  logic        hpl_on, hpr_on, sc_limit_en_o, soft_rst_o, fs_ref_441_o, pll_en_o, irq_o;
  logic [4:0]  pll_q_o;
  logic [23:0] jack_cfg_o;
  int          fail_count, cmp_count;
  int          srst_seen = 0;
  ccrp_ctrl_regs ccrp_ctrl_regs_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .hpl_short_i(hpl_short_i),
    .hpr_short_i(hpr_short_i), .jack_type_i(jack_type_i), .left_headphone_out_on_o(hpl_on),
    .right_headphone_out_on_o(hpr_on), .sc_limit_en_o(sc_limit_en_o), .soft_rst_o(soft_rst_o),
    .adc_div_x2_o(adc_div_x2_o), .dac_div_x2_o(dac_div_x2_o), .fs_ref_441_o(fs_ref_441_o),
    .pll_en_o(pll_en_o), .pll_q_o(pll_q_o), .pll_p_o(pll_p_o), .jack_cfg_o(jack_cfg_o),
    .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count; four-state equality so an unknown never matches
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
      fail_count++;
    end
  endtask : chk
  // Sample at the falling edge, act at the rising one, so no race with the design
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a, w, b;
    int   n;
    a = 0; w = 0; b = 0; n = 0;
    @(posedge core_clk_i);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b && n < 100) begin
      @(negedge core_clk_i);
      n++;
      a = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid & s_axi_bready;
      if (b) chk(32'(s_axi_bresp), 32'(er), "write resp");
      @(posedge core_clk_i);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) chk(32'h0000_0000, 32'h0000_0001, "write hang");
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic a, r;
    int   n;
    a = 0; r = 0; n = 0;
    @(posedge core_clk_i);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r && n < 100) begin
      @(negedge core_clk_i);
      n++;
      a = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid & s_axi_rready;
      if (r) chk(s_axi_rdata, {24'h00_0000, e}, "read data");
      if (r) chk(32'(s_axi_rresp), 32'(er), "read resp");
      @(posedge core_clk_i);
      if (a) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r) chk(32'h0000_0000, 32'h0000_0001, "read hang");
  endtask : rd
  // Let registered and decoded outputs settle before looking at them
  task automatic wt();
    repeat (4) @(negedge core_clk_i);
  endtask : wt
  // Soft reset pulses seen at falling edges; a one-cycle pulse counts once
  always @(negedge core_clk_i) begin
    if (soft_rst_o === 1'b1) srst_seen++;
  end
  task automatic results();
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #60000;
    fail_count++;
    results();
  end
  // Main sequence
  initial begin
    {nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {hpl_short_i, hpr_short_i, jack_type_i, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    ce_i = 1'b1;
    s_axi_wstrb = 4'h1;
    fail_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(`CCRP_IDX_PAGE, 8'h00, 2'h0);
    rd(`CCRP_IDX_RATE, 8'h00, 2'h0);
    rd(`CCRP_IDX_PLL, 8'h10, 2'h0);
    chk(32'(pll_q_o), 32'h0000_0002, "q reset");
    chk(32'(pll_p_o), 32'h0000_0008, "p reset");
    // Rate codes: divisor x2 is code plus two; reserved codes leave the field alone
    wr(`CCRP_IDX_RATE, 8'hAA, 2'h0);
    wt();
    chk(32'({adc_div_x2_o, dac_div_x2_o}), 32'h0000_00CC, "adc dac div");
    wr(`CCRP_IDX_RATE, 8'hBB, 2'h0);
    rd(`CCRP_IDX_RATE, 8'hAA, 2'h0);
    // Byte lane 0 not strobed: the write is answered but nothing is stored
    s_axi_wstrb <= 4'h0;
    wr(`CCRP_IDX_RATE, 8'h33, 2'h0);
    s_axi_wstrb <= 4'h1;
    rd(`CCRP_IDX_RATE, 8'hAA, 2'h0);
    // PLL wrap codes at the low end of the Q field and both ends of the P field
    wr(`CCRP_IDX_PLL, 8'h80, 2'h0);
    wt();
    chk(32'({pll_en_o, pll_q_o, pll_p_o}), 32'({1'b1, 5'h10, 4'h8}), "pll 80");
    wr(`CCRP_IDX_PLL, 8'h0F, 2'h0);
    wt();
    chk(32'({pll_en_o, pll_q_o, pll_p_o}), 32'({1'b0, 5'h11, 4'h7}), "pll 0f");
    wr(`CCRP_IDX_DPATH, 8'h80, 2'h0);
    wt();
    chk(32'(fs_ref_441_o), 32'h0000_0001, "fs ref");
    // Page 1 holds nothing but the page bit itself
    wr(`CCRP_IDX_PAGE, 8'h01, 2'h0);
    rd(`CCRP_IDX_PAGE, 8'h01, 2'h0);
    wr(`CCRP_IDX_RATE, 8'h11, 2'h2);
    wr(`CCRP_IDX_PAGE, 8'h00, 2'h0);
    rd(`CCRP_IDX_RATE, 8'hAA, 2'h0);
    rd(8'h03, 8'h00, 2'h2);
    rd(`CCRP_IDX_SRST, 8'h00, 2'h0);
    // Auto power-down: trip latches until power off then on
    wr(`CCRP_IDX_IMASK, 8'h07, 2'h0);
    wr(`CCRP_IDX_HPPWR, 8'hC0, 2'h0);
    wr(`CCRP_IDX_SCCTL, 8'h06, 2'h0);
    @(posedge core_clk_i);
    hpl_short_i <= 1'b1;
    wt();
    chk(32'({hpl_on, hpr_on, irq_o}), 32'h0000_0003, "trip");
    @(posedge core_clk_i);
    hpl_short_i <= 1'b0;
    rd(`CCRP_IDX_SCSTAT, 8'h80, 2'h0);
    wr(`CCRP_IDX_HPPWR, 8'h40, 2'h0);
    wr(`CCRP_IDX_HPPWR, 8'hC0, 2'h0);
    wt();
    chk(32'(hpl_on), 32'h0000_0001, "repowered");
    rd(`CCRP_IDX_SCSTAT, 8'h00, 2'h0);
    // Clock enable low: a short must not trip the frozen driver
    ce_i <= 1'b0;
    hpl_short_i <= 1'b1;
    wt();
    chk(32'(hpl_on), 32'h0000_0001, "frozen");
    @(posedge core_clk_i);
    {ce_i, hpl_short_i} <= 2'b10;
    wr(`CCRP_IDX_ISTAT, 8'h01, 2'h0);
    wt();
    chk(32'(irq_o), 32'h0000_0000, "irq cleared");
    // Limiting only: driver stays on, status follows the short
    wr(`CCRP_IDX_SCCTL, 8'h04, 2'h0);
    @(posedge core_clk_i);
    hpr_short_i <= 1'b1;
    rd(`CCRP_IDX_SCSTAT, 8'h40, 2'h0);
    chk(32'({hpr_on, sc_limit_en_o, irq_o}), 32'h0000_0007, "limiting");
    hpr_short_i <= 1'b0;
    wr(`CCRP_IDX_ISTAT, 8'h07, 2'h0);
    // Jack type, masked then unmasked event, ac-coupled mono shown as headphone
    wr(`CCRP_IDX_IMASK, 8'h00, 2'h0);
    @(posedge core_clk_i);
    jack_type_i <= 2'h3;
    rd(`CCRP_IDX_JTYPE, 8'h60, 2'h0);
    chk(32'(irq_o), 32'h0000_0000, "masked");
    wr(`CCRP_IDX_IMASK, 8'h04, 2'h0);
    wt();
    chk(32'(irq_o), 32'h0000_0001, "unmasked");
    wr(`CCRP_IDX_JCFG, 8'h80, 2'h0);
    wt();
    chk(32'(jack_cfg_o), 32'h0080_0000, "jack cfg");
    @(posedge core_clk_i);
    jack_type_i <= 2'h2;
    rd(`CCRP_IDX_JTYPE, 8'h20, 2'h0);
    // Soft reset returns every control register to its reset value
    wr(`CCRP_IDX_SRST, 8'h80, 2'h0);
    wt();
    chk(32'({irq_o, pll_q_o, fs_ref_441_o}), 32'({1'b0, 5'h02, 1'b0}), "soft reset");
    chk(32'(srst_seen), 32'h0000_0001, "soft reset pulse");
    rd(`CCRP_IDX_RATE, 8'h00, 2'h0);
    results();
  end
endmodule : ccrp_ctrl_regs_tb
